//--- logic/asmct_ctrl.sv
// Cycle timing and chip-select sequencer for the async static memory port
// Function
// - Read chip-select width is D*(read_wait_states+1)+D cycles.
// - Write chip-select width is D*(write_wait+strobe_length+1)+2D cycles.
// - After DMA read, wait at least 3 cycles before other access.
// - After DMA write, wait at least 1 idle cycle before other access.
// - Halfwords of a 32-bit or burst access run back to back.
// - After processor read, wait at least 4 cycles before DMA access.
// - Decode four 32-Mbyte regions based at 0x00000000, 0x04000000, 0x08000000, 0x0c000000.
// - Upper half of each 64-Mbyte window is reserved, selects nothing.
`default_nettype none
module asmct_ctrl
    import asmct_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire asmct_pkg::asmct_req_t req,
    input wire asmct_pkg::asmct_cfg_t cfg_cs0,
    input wire asmct_pkg::asmct_cfg_t cfg_cs1,
    input wire asmct_pkg::asmct_cfg_t cfg_cs2,
    input wire asmct_pkg::asmct_cfg_t cfg_cs3,
    output logic req_ready,
    output logic req_error,
    output logic [asmct_pkg::CS_COUNT-1:0] cs_n,
    output logic halfword_done,
    output logic busy
);
    import asmct_pkg::*;

    typedef enum logic [1:0] {ASMCT_IDLE, ASMCT_GAP, ASMCT_ACTIVE} asmct_state_t;

    // -------------------------------------------------------------
    // Region decode
    // -------------------------------------------------------------
    logic in_window;
    logic reserved;
    logic [1:0] region;
    asmct_cfg_t sel_cfg;
    logic [CNT_W-1:0] calc_width;

    assign in_window = (req.addr & CS_WINDOW_MASK) == CS_WINDOW_BASE;
    assign reserved = req.addr[CS_RSVD_BIT];
    assign region = req.addr[CS_SEL_LSB +: 2];

    always_comb
    begin
        case (region)
            2'h0: sel_cfg = cfg_cs0;
            2'h1: sel_cfg = cfg_cs1;
            2'h2: sel_cfg = cfg_cs2;
            default: sel_cfg = cfg_cs3;
        endcase
    end

    asmct_width_calc u_width (
        .cfg(sel_cfg),
        .write(req.write),
        .width(calc_width)
    );

    // -------------------------------------------------------------
    // Gap tracking
    // -------------------------------------------------------------
    asmct_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [2:0] hw_left;
    logic [1:0] act_region;
    logic [CNT_W-1:0] act_width;
    logic last_valid;
    logic last_write;
    logic last_cpu;
    logic [2:0] idle_cnt;
    logic [2:0] need_gap;
    logic accept;
    logic start;
    logic bad;
    logic gap_ok;

    // Gap is measured from the last cycle of chip select of the previous access
    always_comb
    begin
        need_gap = GAP_SAME_SEQ;
        if (last_valid)
        begin
            if (last_cpu && !req.from_cpu)
                need_gap = GAP_CPU_RD_TO_DMA;
            else if (!last_cpu && !last_write)
                need_gap = GAP_DMA_RD_TO_OTHER;
            else if (!last_cpu && last_write)
                need_gap = GAP_DMA_WR_TO_OTHER;
        end
    end

    assign bad = !in_window || reserved || req.halfwords == 3'h0
        || (req.from_cpu && req.write);
    assign accept = req.valid && state == ASMCT_IDLE;
    // The high cycle ending at the start edge counts too, so gaps are exact, not one long
    assign gap_ok = ({1'b0, idle_cnt} + 4'h1) >= {1'b0, need_gap};
    assign start = accept && !bad && gap_ok;
    assign req_ready = state == ASMCT_IDLE && (bad || gap_ok);
    assign busy = state != ASMCT_IDLE;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            idle_cnt <= 3'h7;
        else if (state == ASMCT_ACTIVE)
            idle_cnt <= GAP_RESET;
        else if (idle_cnt != 3'h7)
            idle_cnt <= idle_cnt + 3'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            last_valid <= 1'b0;
            last_write <= 1'b0;
            last_cpu <= 1'b0;
        end
        else if (start)
        begin
            last_valid <= 1'b1;
            last_write <= req.write;
            last_cpu <= req.from_cpu;
        end
    end

    // -------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state <= ASMCT_IDLE;
            cnt <= '0;
            hw_left <= 3'h0;
            act_region <= 2'h0;
            act_width <= '0;
        end
        else
        begin
            case (state)
                ASMCT_IDLE:
                begin
                    if (start)
                    begin
                        state <= ASMCT_ACTIVE;
                        cnt <= calc_width;
                        act_width <= calc_width;
                        hw_left <= req.halfwords;
                        act_region <= region;
                    end
                end
                ASMCT_ACTIVE:
                begin
                    if (cnt == CNT_W'(1))
                    begin
                        if (hw_left > 3'h1)
                        begin
                            hw_left <= hw_left - 3'h1;
                            cnt <= act_width;
                        end
                        else
                            state <= ASMCT_IDLE;
                    end
                    else
                        cnt <= cnt - CNT_W'(1);
                end
                default: state <= ASMCT_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cs_n <= '1;
            req_error <= 1'b0;
            halfword_done <= 1'b0;
        end
        else
        begin
            req_error <= accept && bad;
            halfword_done <= state == ASMCT_ACTIVE && cnt == CNT_W'(1);
            if (start)
                cs_n <= ~(CS_COUNT'(1) << region);
            else if (state == ASMCT_ACTIVE && cnt == CNT_W'(1) && hw_left <= 3'h1)
                cs_n <= '1;
        end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_read_width;
        @(posedge mclk) disable iff (!rst_n)
        (start && !req.write && req.halfwords == 3'h1 && sel_cfg.strobe_clock_divide == DIV_BY1
         && sel_cfg.read_wait_states == 4'h0) |=> (cs_n != 4'hf) [*2] ##1 cs_n == 4'hf;
    endproperty
    a_read_width: assert property (p_read_width) else $error("read cs width wrong");

    property p_write_width;
        @(posedge mclk) disable iff (!rst_n)
        (start && req.write && req.halfwords == 3'h1 && sel_cfg.strobe_clock_divide == DIV_BY1
         && sel_cfg.write_wait_states == 4'h0 && sel_cfg.write_strobe_length == 4'h0)
        |=> (cs_n != 4'hf) [*3] ##1 cs_n == 4'hf;
    endproperty
    a_write_width: assert property (p_write_width) else $error("write cs width wrong");

    property p_dma_rd_gap;
        @(posedge mclk) disable iff (!rst_n)
        (start && last_valid && !last_cpu && !last_write)
        |-> cs_n == 4'hf && $past(cs_n) == 4'hf && $past(cs_n, 2) == 4'hf;
    endproperty
    a_dma_rd_gap: assert property (p_dma_rd_gap) else $error("gap after dma read short");

    property p_dma_wr_gap;
        @(posedge mclk) disable iff (!rst_n)
        (start && last_valid && !last_cpu && last_write) |-> cs_n == 4'hf;
    endproperty
    a_dma_wr_gap: assert property (p_dma_wr_gap) else $error("gap after dma write short");

    // After a DMA write, a waiting request must go out after exactly one idle cycle
    property p_dma_wr_allow;
        @(posedge mclk) disable iff (!rst_n)
        (state == ASMCT_IDLE && req.valid && !bad && last_valid && !last_cpu && last_write
         && cs_n == 4'hf && $past(cs_n) != 4'hf) |-> start;
    endproperty
    a_dma_wr_allow: assert property (p_dma_wr_allow) else $error("held off after dma write");

    property p_back_to_back;
        @(posedge mclk) disable iff (!rst_n)
        (state == ASMCT_ACTIVE && cnt == CNT_W'(1) && hw_left > 3'h1) |=> cs_n != 4'hf;
    endproperty
    a_back_to_back: assert property (p_back_to_back) else $error("halfword gap seen");

    property p_cpu_gap;
        @(posedge mclk) disable iff (!rst_n)
        (start && last_valid && last_cpu && !req.from_cpu)
        |-> cs_n == 4'hf && $past(cs_n) == 4'hf && $past(cs_n, 2) == 4'hf
            && $past(cs_n, 3) == 4'hf;
    endproperty
    a_cpu_gap: assert property (p_cpu_gap) else $error("gap after cpu read short");

    property p_decode;
        @(posedge mclk) disable iff (!rst_n)
        start |=> cs_n == ~(4'h1 << $past(region));
    endproperty
    a_decode: assert property (p_decode) else $error("wrong chip select");

    property p_reserved;
        @(posedge mclk) disable iff (!rst_n)
        (accept && req.addr[CS_RSVD_BIT]) |=> req_error && $stable(cs_n);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved area selected");

    property p_cfg_used;
        @(posedge mclk) disable iff (!rst_n)
        start |=> cnt == $past(calc_width);
    endproperty
    a_cfg_used: assert property (p_cfg_used) else $error("region settings not applied");

    c_read: cover property (@(posedge mclk) disable iff (!rst_n) start && !req.write);
    c_write: cover property (@(posedge mclk) disable iff (!rst_n) start && req.write);
    c_burst: cover property (@(posedge mclk) disable iff (!rst_n) start && req.halfwords == 3'h4);
    c_err: cover property (@(posedge mclk) disable iff (!rst_n) req_error);
endmodule
`default_nettype wire

//--- logic/asmct_pkg.sv
// Package of constants and types for the async static memory cycle timing block
`default_nettype none
package asmct_pkg;
    // -------------------------------------------------------------
    // Chip-select map
    // -------------------------------------------------------------
    localparam int unsigned CS_COUNT = 4;
    localparam logic [31:0] CS_WINDOW_MASK = 32'hf000_0000;
    localparam logic [31:0] CS_WINDOW_BASE = 32'h0000_0000;
    localparam int unsigned CS_SEL_LSB = 26;
    localparam int unsigned CS_RSVD_BIT = 25;
    // -------------------------------------------------------------
    // Idle gaps between chip-select activity, in clock cycles
    // -------------------------------------------------------------
    localparam logic [2:0] GAP_DMA_RD_TO_OTHER = 3'h3;
    localparam logic [2:0] GAP_DMA_WR_TO_OTHER = 3'h1;
    localparam logic [2:0] GAP_CPU_RD_TO_DMA = 3'h4;
    localparam logic [2:0] GAP_SAME_SEQ = 3'h0;
    localparam logic [2:0] GAP_RESET = 3'h0;
    // -------------------------------------------------------------
    // Field widths and divide codes
    // -------------------------------------------------------------
    localparam int unsigned WST_W = 4;
    localparam int unsigned CNT_W = 10;
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY4 = 2'h2;
    localparam logic [1:0] DIV_BY6 = 2'h3;

    typedef struct packed {
        logic [WST_W-1:0] read_wait_states;
        logic [WST_W-1:0] write_wait_states;
        logic [WST_W-1:0] write_strobe_length;
        logic [1:0] strobe_clock_divide;
    } asmct_cfg_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic from_cpu;
        logic [2:0] halfwords;
        logic [31:0] addr;
    } asmct_req_t;
endpackage
`default_nettype wire

//--- logic/asmct_width_calc.sv
// Chip-select active width calculator for one halfword of an access
`default_nettype none
module asmct_width_calc
    import asmct_pkg::*;
(
    input wire asmct_pkg::asmct_cfg_t cfg,
    input wire logic write,
    output logic [asmct_pkg::CNT_W-1:0] width
);
    logic [CNT_W-1:0] div;
    logic [CNT_W-1:0] base;
    always_comb
    begin
        case (cfg.strobe_clock_divide)
            DIV_BY1: div = CNT_W'(1);
            DIV_BY2: div = CNT_W'(2);
            DIV_BY4: div = CNT_W'(4);
            default: div = CNT_W'(6);
        endcase
        if (write)
        begin
            base = CNT_W'(cfg.write_wait_states) + CNT_W'(cfg.write_strobe_length)
                + CNT_W'(1);
            width = CNT_W'(div * base + (div << 1));
        end
        else
        begin
            base = CNT_W'(cfg.read_wait_states) + CNT_W'(1);
            width = CNT_W'(div * base + div);
        end
    end
endmodule
`default_nettype wire

//--- verif/asmct_mem_model.sv
// Behavioural model of the static memories hung on the chip selects
`default_nettype none
module asmct_mem_model
    import asmct_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [asmct_pkg::CS_COUNT-1:0] cs_n,
    output logic [15:0] low_len,
    output logic [15:0] gap_len,
    output logic [asmct_pkg::CS_COUNT-1:0] last_sel,
    output logic [7:0] runs
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;

    // ----------------------------------------
    // Select run and idle gap measurement
    // ----------------------------------------
    // No data bus here: only strobe timing is observed
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            low_cnt <= 16'h0000;
            high_cnt <= 16'h0000;
            low_len <= 16'h0000;
            gap_len <= 16'h0000;
            last_sel <= 4'h0;
            runs <= 8'h00;
        end
        else if (cs_n != 4'hf)
        begin
            low_cnt <= low_cnt + 16'h0001;
            if (low_cnt == 16'h0000)
            begin
                gap_len <= high_cnt;
                last_sel <= ~cs_n;
            end
        end
        else
        begin
            high_cnt <= (low_cnt != 16'h0000) ? 16'h0001 : high_cnt + 16'h0001;
            if (low_cnt != 16'h0000)
            begin
                low_len <= low_cnt;
                runs <= runs + 8'h01;
            end
            low_cnt <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

//--- verif/asmct_test.sv
// Self-checking bench for the async static memory cycle timing block
`default_nettype none
module asmct_test;
    timeunit 1ns;
    timeprecision 1ns;
    import asmct_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    asmct_req_t req = '0;
    asmct_cfg_t cfg [4] = '{default: '0};
    logic req_ready;
    logic req_error;
    logic [3:0] cs_n;
    logic halfword_done;
    logic busy;
    logic [15:0] low_len;
    logic [15:0] gap_len;
    logic [3:0] last_sel;
    logic [7:0] runs;
    int err_total = 0;
    int samples_checked = 0;
    int hw_pulses = 0;

    initial
    begin
        forever #20 mclk = ~mclk;
    end

    asmct_ctrl dut (.mclk(mclk), .rst_n(rst_n), .req(req), .cfg_cs0(cfg[0]),
        .cfg_cs1(cfg[1]), .cfg_cs2(cfg[2]), .cfg_cs3(cfg[3]), .req_ready(req_ready),
        .req_error(req_error), .cs_n(cs_n), .halfword_done(halfword_done), .busy(busy));
    asmct_mem_model mem (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .low_len(low_len),
        .gap_len(gap_len), .last_sel(last_sel), .runs(runs));

    // Pulses counted here so the width scenario can compare halfword totals
    always @(posedge mclk)
    begin
        if (halfword_done === 1'b1)
            hw_pulses <= hw_pulses + 1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic give_up(input string what);
        err_total++;
        $display("[ERR] %s expected done seen timeout", what);
        print_verdict();
    endtask

    // Leaves valid up so a second request can follow without a gap
    task automatic send(input logic wr, cpu, input logic [2:0] hw, input logic [31:0] a);
        int n;
        n = 0;
        req = '{1'b1, wr, cpu, hw, a};
        #1;
        while (req_ready !== 1'b1)
        begin
            @(negedge mclk);
            n++;
            if (n > 300)
                give_up("req_ready");
        end
        @(negedge mclk);
    endtask

    task automatic wait_runs(input logic [7:0] target);
        int n;
        n = 0;
        while (runs !== target)
        begin
            @(negedge mclk);
            n++;
            if (n > 400)
                give_up("transfer end");
        end
    endtask

    function automatic logic [31:0] width(input asmct_cfg_t c, input logic wr);
        logic [31:0] d;
        d = (c.strobe_clock_divide == DIV_BY1) ? 1 : (c.strobe_clock_divide == DIV_BY2) ? 2 :
            (c.strobe_clock_divide == DIV_BY4) ? 4 : 6;
        if (wr)
            return d * (c.write_wait_states + c.write_strobe_length + 1) + 2 * d;
        return d * (c.read_wait_states + 1) + d;
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_widths();
        logic [31:0] a;
        logic [2:0] hw;
        logic [7:0] r;
        int p;
        for (int i = 0; i < 4; i++)
            cfg[i] = '{4'(i + 2), 4'(3 - i), 4'(i), 2'(i)};
        for (int i = 0; i < 4; i++)
        begin
            a = (32'(i) << 26) | 32'h01ff_fffe;
            for (int k = 0; k < 4; k++)
            begin
                hw = (k < 2) ? 3'h1 : 3'(2 * (k - 1));
                r = runs;
                p = hw_pulses;
                send(k[0], 1'b0, hw, a);
                req.valid = 1'b0;
                wait_runs(r + 8'h01);
                chk("cs width", hw * width(cfg[i], k[0]), low_len);
                chk("cs line", 32'(1 << i), last_sel);
                chk("halfword_done pulses", 32'(hw), 32'(hw_pulses - p));
            end
        end
        $display("test widths done");
    endtask

    task automatic t_gaps();
        logic [5:0] f_wr = 6'b001100;
        logic [5:0] f_cpu = 6'b110000;
        logic [5:0] s_wr = 6'b100001;
        logic [5:0] s_cpu = 6'b001010;
        logic [31:0] mins [6] = '{3, 3, 1, 1, 4, 4};
        logic [7:0] r;
        for (int j = 0; j < 6; j++)
        begin
            r = runs;
            send(f_wr[j], f_cpu[j], 3'h2, 32'h0400_0100);
            send(s_wr[j], s_cpu[j], 3'h2, 32'h0400_0200);
            req.valid = 1'b0;
            wait_runs(r + 8'h02);
            chk("gap", mins[j], 32'(gap_len));
        end
        $display("test gaps done");
    endtask

    task automatic t_refuse();
        logic [31:0] addrs [5] = '{32'h0200_0000, 32'h0e00_0010, 32'h1000_0000, 0, 32'h0400_0000};
        for (int j = 0; j < 5; j++)
        begin
            send(j == 4, j == 4, (j == 3) ? 3'h0 : 3'h1, addrs[j]);
            req.valid = 1'b0;
            chk("req_error", 1, req_error);
            chk("cs_n refused", 32'hf, cs_n);
            @(negedge mclk);
            chk("req_error end", 0, req_error);
            chk("cs_n refused", 32'hf, cs_n);
        end
        $display("test refusals done");
    endtask

    // Zero settings at divide by one: shortest read and write strobes
    task automatic t_min();
        logic [7:0] r;
        cfg[0] = '0;
        for (int k = 0; k < 2; k++)
        begin
            r = runs;
            send(k[0], 1'b0, 3'h1, 32'h0000_0010);
            req.valid = 1'b0;
            wait_runs(r + 8'h01);
            chk("cs width min", 32'(2 + k), low_len);
        end
        $display("test minimum widths done");
    endtask

    initial
    begin
        repeat (2) @(negedge mclk);
        chk("cs_n reset", 32'hf, cs_n);
        chk("busy reset", 0, busy);
        chk("halfword_done reset", 0, halfword_done);
        rst_n = 1'b1;
        t_widths();
        t_gaps();
        t_refuse();
        send(1'b0, 1'b0, 3'h4, 32'h0c00_0000);
        req.valid = 1'b0;
        @(negedge mclk);
        chk("cs_n before reset", 32'h7, cs_n);
        rst_n = 1'b0;
        @(negedge mclk);
        chk("cs_n mid reset", 32'hf, cs_n);
        chk("busy mid reset", 0, busy);
        chk("halfword_done mid reset", 0, halfword_done);
        rst_n = 1'b1;
        $display("test mid reset done");
        t_min();
        print_verdict();
    end
endmodule
`default_nettype wire
